// ===== hw/tcc_brake.sv
`timescale 1ns/1ps
module tcc_brake (
  // Inputs
  input  wire logic       level_i,
  input  wire logic       brake_i,
  input  wire logic       cap_mode_i,
  input  wire logic [1:0] sel_i,
  // Next pin state
  output logic            next_pin_o,
  output logic            next_oe_o
);

  wire force_low  = brake_i && sel_i == tcc_pkg::BRK_LOW;
  wire force_high = brake_i && sel_i == tcc_pkg::BRK_HIGH;
  wire float_out  = brake_i && sel_i == tcc_pkg::BRK_HIZ;

  assign next_oe_o  = !cap_mode_i && !float_out; // RULE11 RULE13
  assign next_pin_o = force_high || (!force_low && level_i);

endmodule

// ===== hw/tcc_ch1.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
// Overview of operation
// RULE1: Writing one to B trigger fires a B event; hardware clears the bit.
// RULE2: Writing one to A trigger fires an A event; hardware clears the bit.
// RULE3: In compare mode a software trigger only raises the interrupt.
// RULE4: In capture mode a trigger raises interrupt and captures the counter.
// RULE5: Centre-aligned B match interrupt: none, up, down or both directions.
// RULE6: Centre-aligned A match interrupt selection comes from main timer control.
// RULE7: An event raises a DMA request only when its DMA enable is set.
// RULE8: An event raises an interrupt only when its interrupt enable is set.
// RULE9: Bits 7 and 6 enable compare shadow buffering for B and A.
// RULE10: Bits 5 and 4 select compare (0) or capture (1) per sub-channel.
// RULE11: Compare mode B brake field: float, unchanged, low or high.
// RULE12: Capture mode B field selects no, rising, falling or both edges.
// RULE13: Compare mode A brake field: float, unchanged, low or high.
// RULE14: Capture mode A field selects no, rising, falling or both edges.
// RULE15: Control register at 0x24 resets to 0x00003000.
// RULE16: Software keeps the upper sixteen control bits at reset value.
// RULE17: Brake levels apply only while the global brake enable is set.
// RULE18: Buffered writes go to the shadow; active loads on update event.
// RULE19: A trigger bit reads one for at most one clock, then zero.
module tcc_ch1 (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // Timer core
  input  wire logic [15:0] cnt_i,
  input  wire logic        cnt_up_i,
  input  wire logic        center_i,
  input  wire logic        update_i,
  input  wire logic        brake_evt_i,
  input  wire logic        global_brake_enable_i,
  input  wire logic [1:0]  center_irq_select_sub_a_i,
  // Channel pins
  input  wire logic        pin_a_i,
  output logic             pin_a_o,
  output logic             pin_a_oe_o,
  input  wire logic        pin_b_i,
  output logic             pin_b_o,
  output logic             pin_b_oe_o,
  // Requests
  output logic             irq_o,
  output logic             dma_req_a_o,
  output logic             dma_req_b_o
);

  // ------------------------------------------------
  // State
  // ------------------------------------------------
  logic [15:0] ctrl;
  logic [1:0]  status;
  logic [1:0]  mask;
  logic [1:0]  next_status;
  logic [31:0] next_rdata;

  // ------------------------------------------------
  // Address decode
  // ------------------------------------------------
  wire wr_ctrl = wr_i && addr_i == tcc_pkg::CTRL_OFS;
  wire wr_ccra = wr_i && addr_i == tcc_pkg::CCRA_OFS;
  wire wr_ccrb = wr_i && addr_i == tcc_pkg::CCRB_OFS;
  wire wr_mask = wr_i && addr_i == tcc_pkg::MASK_OFS;
  wire rd_stat = rd_i && addr_i == tcc_pkg::STAT_OFS;

  // ------------------------------------------------
  // Control fields
  // ------------------------------------------------
  wire       soft_trigger_sub_b           = ctrl[tcc_pkg::TRIG_B];
  wire       soft_trigger_sub_a           = ctrl[tcc_pkg::TRIG_A];
  wire [1:0] center_irq_select_sub_b      = ctrl[tcc_pkg::CENTER_IRQ_SELECT_SUB_B_LO +: 2];
  wire       dma_request_enable_sub_b     = ctrl[tcc_pkg::DMA_B];
  wire       dma_request_enable_sub_a     = ctrl[tcc_pkg::DMA_A];
  wire       irq_enable_sub_b             = ctrl[tcc_pkg::IE_B];
  wire       irq_enable_sub_a             = ctrl[tcc_pkg::IE_A];
  wire       compare_shadow_enable_sub_b  = ctrl[tcc_pkg::SHD_B];
  wire       compare_shadow_enable_sub_a  = ctrl[tcc_pkg::SHD_A];
  wire       function_select_sub_b        = ctrl[tcc_pkg::FSEL_B]; // RULE10
  wire       function_select_sub_a        = ctrl[tcc_pkg::FSEL_A]; // RULE10
  wire [1:0] brake_or_edge_sub_b          = ctrl[tcc_pkg::BKE_B +: 2];
  wire [1:0] brake_or_edge_sub_a          = ctrl[tcc_pkg::BKE_A +: 2];

  // ------------------------------------------------
  // Sub-channels
  // ------------------------------------------------
  logic [15:0] ccr_a;
  logic [15:0] ccr_b;
  logic [15:0] act_a;
  logic [15:0] act_b;
  logic        irq_ev_a;
  logic        irq_ev_b;
  logic        dma_ev_a;
  logic        dma_ev_b;
  logic        level_a;
  logic        level_b;

  tcc_sub u_sub_a (
    .mclk_i      (mclk_i),
    .nrst_i      (nrst_i),
    .cnt_i       (cnt_i),
    .cnt_up_i    (cnt_up_i),
    .center_i    (center_i),
    .update_i    (update_i),
    .pin_i       (pin_a_i),
    .cap_mode_i  (function_select_sub_a),
    .shadow_en_i (compare_shadow_enable_sub_a),
    .soft_trig_i (soft_trigger_sub_a), // RULE2
    .edge_sel_i  (brake_or_edge_sub_a), // RULE14
    .cis_i       (center_irq_select_sub_a_i), // RULE6
    .wr_i        (wr_ccra),
    .wdata_i     (wdata_i[15:0]),
    .ccr_o       (ccr_a),
    .active_o    (act_a),
    .irq_ev_o    (irq_ev_a),
    .dma_ev_o    (dma_ev_a),
    .level_o     (level_a)
  );

  tcc_sub u_sub_b (
    .mclk_i      (mclk_i),
    .nrst_i      (nrst_i),
    .cnt_i       (cnt_i),
    .cnt_up_i    (cnt_up_i),
    .center_i    (center_i),
    .update_i    (update_i),
    .pin_i       (pin_b_i),
    .cap_mode_i  (function_select_sub_b),
    .shadow_en_i (compare_shadow_enable_sub_b),
    .soft_trig_i (soft_trigger_sub_b), // RULE1
    .edge_sel_i  (brake_or_edge_sub_b), // RULE12
    .cis_i       (center_irq_select_sub_b), // RULE5
    .wr_i        (wr_ccrb),
    .wdata_i     (wdata_i[15:0]),
    .ccr_o       (ccr_b),
    .active_o    (act_b),
    .irq_ev_o    (irq_ev_b),
    .dma_ev_o    (dma_ev_b),
    .level_o     (level_b)
  );

  // ------------------------------------------------
  // Brake and pin drive
  // ------------------------------------------------
  wire brake_on = brake_evt_i && global_brake_enable_i; // RULE17
  logic next_pin_a;
  logic next_oe_a;
  logic next_pin_b;
  logic next_oe_b;

  tcc_brake u_brake_a (
    .level_i    (level_a),
    .brake_i    (brake_on),
    .cap_mode_i (function_select_sub_a),
    .sel_i      (brake_or_edge_sub_a), // RULE13
    .next_pin_o (next_pin_a),
    .next_oe_o  (next_oe_a)
  );

  tcc_brake u_brake_b (
    .level_i    (level_b),
    .brake_i    (brake_on),
    .cap_mode_i (function_select_sub_b),
    .sel_i      (brake_or_edge_sub_b), // RULE11
    .next_pin_o (next_pin_b),
    .next_oe_o  (next_oe_b)
  );

  // ------------------------------------------------
  // Events, status and read mux
  // ------------------------------------------------
  wire [1:0] irq_set = {irq_ev_b && irq_enable_sub_b, irq_ev_a && irq_enable_sub_a}; // RULE8
  wire       next_dma_a = dma_ev_a && dma_request_enable_sub_a; // RULE7
  wire       next_dma_b = dma_ev_b && dma_request_enable_sub_b; // RULE7

  assign next_status = (status & {2{!rd_stat}}) | irq_set;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        tcc_pkg::CTRL_OFS: next_rdata = {16'h0000, ctrl}; // RULE16
        tcc_pkg::CCRA_OFS: next_rdata = {16'h0000, ccr_a};
        tcc_pkg::CCRB_OFS: next_rdata = {16'h0000, ccr_b};
        tcc_pkg::STAT_OFS: next_rdata = {30'h0000_0000, status};
        tcc_pkg::MASK_OFS: next_rdata = {30'h0000_0000, mask};
        default:           next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------
  // Registers
  // ------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      ctrl <= tcc_pkg::CTRL_RST; // RULE15
    end else if (wr_ctrl) begin
      ctrl <= wdata_i[15:0];
    end else begin
      ctrl[tcc_pkg::TRIG_B] <= 1'b0; // RULE1 RULE19
      ctrl[tcc_pkg::TRIG_A] <= 1'b0; // RULE2 RULE19
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      status <= tcc_pkg::EVT_RST;
      mask   <= tcc_pkg::EVT_RST;
    end else begin
      status <= next_status;
      if (wr_mask) begin
        mask <= wdata_i[1:0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      rdata_o     <= 32'h0000_0000;
      irq_o       <= 1'b0;
      dma_req_a_o <= 1'b0;
      dma_req_b_o <= 1'b0;
      pin_a_o     <= 1'b0;
      pin_a_oe_o  <= 1'b0;
      pin_b_o     <= 1'b0;
      pin_b_oe_o  <= 1'b0;
    end else begin
      rdata_o     <= next_rdata;
      irq_o       <= |(next_status & mask);
      dma_req_a_o <= next_dma_a;
      dma_req_b_o <= next_dma_b;
      pin_a_o     <= next_pin_a;
      pin_a_oe_o  <= next_oe_a;
      pin_b_o     <= next_pin_b;
      pin_b_oe_o  <= next_oe_b;
    end
  end

  // ------------------------------------------------
  // Checks
  // ------------------------------------------------
  a_trig_b_event: assert property ( // RULE1
    @(posedge mclk_i) disable iff (!nrst_i)
    soft_trigger_sub_b && irq_enable_sub_b |=> status[tcc_pkg::STAT_B])
    else $error("B trigger did not set status");

  a_trig_a_event: assert property ( // RULE2
    @(posedge mclk_i) disable iff (!nrst_i)
    soft_trigger_sub_a && irq_enable_sub_a |=> status[tcc_pkg::STAT_A])
    else $error("A trigger did not set status");

  a_compare_no_capture: assert property ( // RULE3
    @(posedge mclk_i) disable iff (!nrst_i)
    soft_trigger_sub_a && !function_select_sub_a && !wr_ccra |=> ccr_a == $past(ccr_a))
    else $error("Compare trigger changed register");

  a_capture_counter: assert property ( // RULE4
    @(posedge mclk_i) disable iff (!nrst_i)
    soft_trigger_sub_b && function_select_sub_b |=> ccr_b == $past(cnt_i))
    else $error("Capture did not take counter");

  a_dma_gate_a: assert property ( // RULE7
    @(posedge mclk_i) disable iff (!nrst_i)
    dma_req_a_o |-> $past(dma_request_enable_sub_a) && $past(dma_ev_a))
    else $error("DMA A without enable");

  a_irq_gate_b: assert property ( // RULE8
    @(posedge mclk_i) disable iff (!nrst_i)
    $rose(status[tcc_pkg::STAT_B]) |-> $past(irq_enable_sub_b))
    else $error("Status B set without enable");

  a_shadow_hold: assert property ( // RULE18
    @(posedge mclk_i) disable iff (!nrst_i)
    wr_ccra && compare_shadow_enable_sub_a && !function_select_sub_a && !update_i
    |=> act_a == $past(act_a))
    else $error("Buffered write hit active value");

  a_brake_low_b: assert property ( // RULE11
    @(posedge mclk_i) disable iff (!nrst_i)
    brake_on && !function_select_sub_b && brake_or_edge_sub_b == tcc_pkg::BRK_LOW
    |=> pin_b_oe_o && !pin_b_o)
    else $error("Brake low not driven on B");

  a_brake_float_a: assert property ( // RULE13
    @(posedge mclk_i) disable iff (!nrst_i)
    brake_on && brake_or_edge_sub_a == tcc_pkg::BRK_HIZ |=> !pin_a_oe_o)
    else $error("Brake float not released on A");

  a_capture_release: assert property ( // RULE14
    @(posedge mclk_i) disable iff (!nrst_i)
    function_select_sub_a [*2] |-> !pin_a_oe_o)
    else $error("Capture pin driven");

  a_ctrl_reset: assert property ( // RULE15
    @(posedge mclk_i)
    !nrst_i |=> ctrl == tcc_pkg::CTRL_RST)
    else $error("Control reset value wrong");

  a_no_brake_off: assert property ( // RULE17
    @(posedge mclk_i) disable iff (!nrst_i)
    !global_brake_enable_i && !function_select_sub_b |=> pin_b_o == $past(level_b))
    else $error("Brake acted while disabled");

  a_trig_self_clear: assert property ( // RULE19
    @(posedge mclk_i) disable iff (!nrst_i)
    soft_trigger_sub_a && !wr_ctrl |=> !soft_trigger_sub_a)
    else $error("Trigger bit did not clear");

  a_trig_b_clear: assert property ( // RULE1
    @(posedge mclk_i) disable iff (!nrst_i)
    soft_trigger_sub_b && !wr_ctrl |=> !soft_trigger_sub_b)
    else $error("B trigger bit did not clear");

  a_compare_keep_b: assert property ( // RULE3
    @(posedge mclk_i) disable iff (!nrst_i)
    soft_trigger_sub_b && !function_select_sub_b && !wr_ccrb |=> ccr_b == $past(ccr_b))
    else $error("B compare trigger changed register");

  a_capture_counter_a: assert property ( // RULE4
    @(posedge mclk_i) disable iff (!nrst_i)
    soft_trigger_sub_a && function_select_sub_a |=> ccr_a == $past(cnt_i))
    else $error("A capture did not take counter");

  a_center_b_none: assert property ( // RULE5
    @(posedge mclk_i) disable iff (!nrst_i)
    center_i && !function_select_sub_b && !soft_trigger_sub_b
    && center_irq_select_sub_b == tcc_pkg::CIS_NONE |-> !irq_ev_b)
    else $error("B match irq while not selected");

  a_center_a_none: assert property ( // RULE6
    @(posedge mclk_i) disable iff (!nrst_i)
    center_i && !function_select_sub_a && !soft_trigger_sub_a
    && center_irq_select_sub_a_i == tcc_pkg::CIS_NONE |-> !irq_ev_a)
    else $error("A match irq while not selected");

  a_dma_gate_b: assert property ( // RULE7
    @(posedge mclk_i) disable iff (!nrst_i)
    dma_req_b_o |-> $past(dma_request_enable_sub_b) && $past(dma_ev_b))
    else $error("DMA B without enable");

  a_irq_gate_a: assert property ( // RULE8
    @(posedge mclk_i) disable iff (!nrst_i)
    $rose(status[tcc_pkg::STAT_A]) |-> $past(irq_enable_sub_a))
    else $error("Status A set without enable");

  a_brake_high_a: assert property ( // RULE13
    @(posedge mclk_i) disable iff (!nrst_i)
    brake_on && !function_select_sub_a && brake_or_edge_sub_a == tcc_pkg::BRK_HIGH
    |=> pin_a_oe_o && pin_a_o)
    else $error("Brake high not driven on A");

endmodule

// ===== hw/tcc_pkg.sv
package tcc_pkg;

  // ------------------------------------------------
  // Register offsets
  // ------------------------------------------------
  localparam logic [7:0]  CTRL_OFS = 8'h24;
  localparam logic [7:0]  CCRA_OFS = 8'h3c;
  localparam logic [7:0]  CCRB_OFS = 8'h40;
  localparam logic [7:0]  STAT_OFS = 8'h60;
  localparam logic [7:0]  MASK_OFS = 8'h64;

  // ------------------------------------------------
  // Reset values
  // ------------------------------------------------
  localparam logic [15:0] CTRL_RST = 16'h3000;
  localparam logic [15:0] CCR_RST  = 16'h0000;
  localparam logic [1:0]  EVT_RST  = 2'h0;

  // ------------------------------------------------
  // Control field positions
  // ------------------------------------------------
  localparam int TRIG_B  = 15;
  localparam int TRIG_A  = 14;
  localparam int CENTER_IRQ_SELECT_SUB_B_LO = 12;
  localparam int DMA_B   = 11;
  localparam int DMA_A   = 10;
  localparam int IE_B    = 9;
  localparam int IE_A    = 8;
  localparam int SHD_B   = 7;
  localparam int SHD_A   = 6;
  localparam int FSEL_B  = 5;
  localparam int FSEL_A  = 4;
  localparam int BKE_B   = 2;
  localparam int BKE_A   = 0;
  localparam int STAT_A  = 0;
  localparam int STAT_B  = 1;

  // ------------------------------------------------
  // Field codes
  // ------------------------------------------------
  localparam logic [1:0] BRK_HIZ  = 2'h0;
  localparam logic [1:0] BRK_LOW  = 2'h2;
  localparam logic [1:0] BRK_HIGH = 2'h3;
  localparam logic [1:0] EDG_RISE = 2'h1;
  localparam logic [1:0] EDG_FALL = 2'h2;
  localparam logic [1:0] EDG_BOTH = 2'h3;
  localparam logic [1:0] CIS_NONE = 2'h0;
  localparam logic [1:0] CIS_UP   = 2'h1;
  localparam logic [1:0] CIS_DOWN = 2'h2;

  // ------------------------------------------------
  // Shared decoders
  // ------------------------------------------------
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    logic r;
    logic f;
    r = !prev && cur;
    f = prev && !cur;
    edge_hit = (sel == EDG_RISE && r) || (sel == EDG_FALL && f) || (sel == EDG_BOTH && (r || f));
  endfunction

  function automatic logic cis_ok(input logic [1:0] sel, input logic center, input logic up);
    if (!center) begin
      cis_ok = 1'b1;
    end else begin
      case (sel)
        CIS_NONE: cis_ok = 1'b0;
        CIS_UP:   cis_ok = up;
        CIS_DOWN: cis_ok = !up;
        default:  cis_ok = 1'b1;
      endcase
    end
  endfunction

endpackage

// ===== hw/tcc_sub.sv
`timescale 1ns/1ps
module tcc_sub (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // Timer state
  input  wire logic [15:0] cnt_i,
  input  wire logic        cnt_up_i,
  input  wire logic        center_i,
  input  wire logic        update_i,
  // Pin and control
  input  wire logic        pin_i,
  input  wire logic        cap_mode_i,
  input  wire logic        shadow_en_i,
  input  wire logic        soft_trig_i,
  input  wire logic [1:0]  edge_sel_i,
  input  wire logic [1:0]  cis_i,
  // Register write
  input  wire logic        wr_i,
  input  wire logic [15:0] wdata_i,
  // Results
  output logic      [15:0] ccr_o,
  output logic      [15:0] active_o,
  output logic             irq_ev_o,
  output logic             dma_ev_o,
  output logic             level_o
);

  logic        pin_q;
  logic [15:0] cnt_q;
  logic [15:0] ccr;
  logic [15:0] active;

  wire edge_ev   = cap_mode_i && tcc_pkg::edge_hit(edge_sel_i, pin_q, pin_i); // RULE12 RULE14
  wire match     = !cap_mode_i && cnt_i == active && cnt_i != cnt_q;
  wire match_irq = match && tcc_pkg::cis_ok(cis_i, center_i, cnt_up_i); // RULE5
  wire capture   = edge_ev || (cap_mode_i && soft_trig_i); // RULE4
  wire load_now  = !cap_mode_i && wr_i && !shadow_en_i; // RULE9
  wire load_upd  = !cap_mode_i && shadow_en_i && update_i; // RULE18

  assign irq_ev_o = soft_trig_i || edge_ev || match_irq; // RULE3
  assign dma_ev_o = capture || match;
  assign level_o  = cnt_i < active;
  assign ccr_o    = ccr;
  assign active_o = active;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      pin_q  <= 1'b0;
      cnt_q  <= tcc_pkg::CCR_RST;
      ccr    <= tcc_pkg::CCR_RST;
      active <= tcc_pkg::CCR_RST;
    end else begin
      pin_q <= pin_i;
      cnt_q <= cnt_i;
      if (capture) begin
        ccr <= cnt_i; // RULE4
      end else if (wr_i) begin
        ccr <= wdata_i;
      end
      if (load_now) begin
        active <= wdata_i;
      end else if (load_upd) begin
        active <= ccr; // RULE18
      end
    end
  end

endmodule

// ===== testbench/tcc_pin_model.sv
`timescale 1ns/1ps
module tcc_pin_model (
  // Clock
  input  wire logic mclk_i,
  // Channel side of the pin
  input  wire logic dut_lvl_i,
  input  wire logic dut_oe_i,
  // Outside source
  input  wire logic ext_en_i,
  input  wire logic ext_lvl_i,
  // Resolved pin level
  output logic      wire_o
);
  // ----------------------------------------
  // Pin resolution
  // ----------------------------------------
  logic last = 1'b0;

  // An undriven pin must not hold its last value, so it flips every cycle
  always_comb begin
    if (dut_oe_i) begin
      wire_o = dut_lvl_i;
    end else if (ext_en_i) begin
      wire_o = ext_lvl_i;
    end else begin
      wire_o = ~last;
    end
  end

  always_ff @(posedge mclk_i) begin
    last <= wire_o;
  end
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        mclk_i, nrst_i, wr_i, rd_i, cnt_up_i, center_i, update_i;
  logic        brake_evt_i, global_brake_enable_i, ext_en, ext_lvl;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [15:0] cnt_i, r1;
  logic [1:0]  center_irq_select_sub_a_i;
  logic        pin_a_i, pin_a_o, pin_a_oe_o, pin_b_i, pin_b_o, pin_b_oe_o;
  logic        irq_o, dma_req_a_o, dma_req_b_o, hit, oe, hi;
  int          bad_count, comparisons, seed, dma_a_n, dma_b_n, ba, bb, c, d;

  tcc_ch1 u_dut (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .cnt_i(cnt_i), .cnt_up_i(cnt_up_i), .center_i(center_i),
    .update_i(update_i), .brake_evt_i(brake_evt_i), .global_brake_enable_i(global_brake_enable_i),
    .center_irq_select_sub_a_i(center_irq_select_sub_a_i), .pin_a_i(pin_a_i), .pin_a_o(pin_a_o),
    .pin_a_oe_o(pin_a_oe_o), .pin_b_i(pin_b_i), .pin_b_o(pin_b_o), .pin_b_oe_o(pin_b_oe_o),
    .irq_o(irq_o), .dma_req_a_o(dma_req_a_o), .dma_req_b_o(dma_req_b_o));
  tcc_pin_model u_pin_a (.mclk_i(mclk_i), .dut_lvl_i(pin_a_o), .dut_oe_i(pin_a_oe_o),
    .ext_en_i(ext_en), .ext_lvl_i(ext_lvl), .wire_o(pin_a_i));
  tcc_pin_model u_pin_b (.mclk_i(mclk_i), .dut_lvl_i(pin_b_o), .dut_oe_i(pin_b_oe_o),
    .ext_en_i(ext_en), .ext_lvl_i(ext_lvl), .wire_o(pin_b_i));

  // ----------------------------------------
  // Clock, request counters, watchdog
  // ----------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    if (dma_req_a_o === 1'b1) dma_a_n++;
    if (dma_req_b_o === 1'b1) dma_b_n++;
  end

  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end

  // ----------------------------------------
  // Tasks and functions
  // ----------------------------------------
  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input bit cmp = 1'b1);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    if (cmp) chk(rdata_o, exp);
  endtask

  // Centre-aligned match irq expected for a select code and direction
  function automatic logic cis_exp(input int s, input int up);
    return s == 3 || (s == 1 && up == 1) || (s == 2 && up == 0);
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 15032;
    {nrst_i, wr_i, rd_i, cnt_up_i, center_i, update_i, brake_evt_i} = '0;
    {global_brake_enable_i, ext_en, ext_lvl, center_irq_select_sub_a_i} = '0;
    addr_i = 8'h00;
    wdata_i = 32'h0000_0000;
    cnt_i = 16'h0000;
    {bad_count, comparisons, dma_a_n, dma_b_n} = '0;
    repeat (4) @(posedge mclk_i);
    nrst_i <= 1'b1;
    rd(tcc_pkg::CTRL_OFS, 32'h0000_3000);
    rd(tcc_pkg::STAT_OFS, 32'h0000_0000);
    rd(tcc_pkg::MASK_OFS, 32'h0000_0000);
    rd(tcc_pkg::CCRA_OFS, 32'h0000_0000);
    rd(8'h70, 32'h0000_0000);
    // Compare-mode triggers, A with its irq disabled
    r1 = 16'($random(seed));
    wr(tcc_pkg::CCRB_OFS, {16'h0000, r1});
    rd(tcc_pkg::CCRB_OFS, {16'h0000, r1});
    wr(tcc_pkg::MASK_OFS, 32'h0000_0001);
    wr(tcc_pkg::CTRL_OFS, 32'h0000_fe00);
    cyc(2);
    chk(irq_o, 32'h0);
    wr(tcc_pkg::MASK_OFS, 32'h0000_0003);
    cyc(2);
    chk(irq_o, 32'h1);
    rd(tcc_pkg::CTRL_OFS, 32'h0000_3e00);
    rd(tcc_pkg::STAT_OFS, 32'h0000_0002);
    cyc(2);
    chk(irq_o, 32'h0);
    rd(tcc_pkg::CCRB_OFS, {16'h0000, r1});
    chk(32'(dma_a_n + dma_b_n), 32'h0);
    // Capture-mode trigger on A
    r1 = 16'($random(seed));
    cnt_i <= r1;
    wr(tcc_pkg::CTRL_OFS, 32'h0000_7110);
    cyc(2);
    rd(tcc_pkg::CTRL_OFS, 32'h0000_3110);
    rd(tcc_pkg::STAT_OFS, 32'h0000_0001);
    rd(tcc_pkg::CCRA_OFS, {16'h0000, r1});
    // Pin capture, every edge code on both sub-channels
    ext_en <= 1'b1;
    ext_lvl <= 1'b0;
    for (c = 0; c < 4; c++) begin
      wr(tcc_pkg::CTRL_OFS, {16'h0000, 12'h333, 2'(c), 2'(c)});
      cyc(3);
      rd(tcc_pkg::STAT_OFS, 32'h0, 1'b0);
      for (d = 0; d < 2; d++) begin
        r1 = 16'($random(seed));
        cnt_i <= r1;
        ext_lvl <= (d == 0);
        cyc(3);
        hit = (c == 3) || (c == 1 && d == 0) || (c == 2 && d == 1);
        chk(irq_o, {31'h0, hit});
        chk(pin_a_oe_o | pin_b_oe_o, 32'h0);
        rd(tcc_pkg::STAT_OFS, {30'h0, hit, hit});
        if (hit) begin
          rd(tcc_pkg::CCRA_OFS, {16'h0000, r1});
          rd(tcc_pkg::CCRB_OFS, {16'h0000, r1});
        end
      end
    end
    // Brake levels against the global enable
    wr(tcc_pkg::CTRL_OFS, 32'h0000_3000);
    ext_en <= 1'b0;
    wr(tcc_pkg::CCRA_OFS, 32'h0000_0010);
    wr(tcc_pkg::CCRB_OFS, 32'h0000_0010);
    cnt_i <= 16'h0100;
    brake_evt_i <= 1'b1;
    for (c = 0; c < 4; c++) begin
      for (d = 0; d < 2; d++) begin
        global_brake_enable_i <= d[0];
        wr(tcc_pkg::CTRL_OFS, {16'h0000, 12'h300, 2'(c), 2'(c)});
        cyc(3);
        oe = !(d == 1 && c == 0);
        hi = (d == 1 && c == 3);
        chk(pin_a_oe_o, {31'h0, oe});
        chk(pin_b_oe_o, {31'h0, oe});
        if (oe) chk({pin_b_o, pin_a_o}, {30'h0, hi, hi});
      end
    end
    brake_evt_i <= 1'b0;
    global_brake_enable_i <= 1'b0;
    // Shadowed compare value on A
    wr(tcc_pkg::CTRL_OFS, 32'h0000_3040);
    wr(tcc_pkg::CCRA_OFS, 32'h0000_ffff);
    cyc(3);
    chk(pin_a_o, 32'h0);
    rd(tcc_pkg::CCRA_OFS, 32'h0000_ffff);
    update_i <= 1'b1;
    cyc(1);
    update_i <= 1'b0;
    cyc(3);
    chk(pin_a_o, 32'h1);
    // Centre-aligned match irq selection, DMA on B only
    wr(tcc_pkg::CTRL_OFS, 32'h0000_0b00);
    wr(tcc_pkg::CCRA_OFS, 32'h0000_0050);
    wr(tcc_pkg::CCRB_OFS, 32'h0000_0050);
    center_i <= 1'b1;
    ba = dma_a_n;
    bb = dma_b_n;
    for (c = 0; c < 4; c++) begin
      center_irq_select_sub_a_i <= 2'(c);
      wr(tcc_pkg::CTRL_OFS, {16'h0000, 2'h0, 2'(3 - c), 12'hb00});
      for (d = 0; d < 2; d++) begin
        cnt_up_i <= d[0];
        cnt_i <= 16'h004f;
        cyc(2);
        rd(tcc_pkg::STAT_OFS, 32'h0, 1'b0);
        cnt_i <= 16'h0050;
        cyc(3);
        rd(tcc_pkg::STAT_OFS, {30'h0, cis_exp(3 - c, d), cis_exp(c, d)});
      end
    end
    chk(32'(dma_b_n - bb), 32'h8);
    chk(32'(dma_a_n - ba), 32'h0);
    give_verdict();
  end
endmodule
